// ### cs_pkg.sv
// shared constants and types for the serial configuration write port
package cs_pkg;

    // word geometry
    localparam int WORD_W    = 32;                 // bits per serial word
    localparam int NUM_WORDS = 4;                  // configuration registers
    localparam int SEL_W     = 2;                  // select field width
    localparam int SEL_LSB   = 0;                  // select field position

    // host side timing
    localparam int CLK_PERIOD_NS = 4;              // host clock period
    localparam int SCLK_HALF_NS  = 20;             // least serial half period
    localparam int SCLK_HALF_RAW =
        (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SCLK_HALF_CYC =
        8'((SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW);
    localparam logic [4:0] LAST_BIT = 5'h1f;       // index of first bit sent

    // word and bank types
    typedef logic [WORD_W-1:0]                 cs_word_t;
    typedef logic [NUM_WORDS-1:0][WORD_W-1:0]  cs_bank_t;
    typedef logic [SEL_W-1:0]                  cs_sel_t;

    // values after power-up or power-down
    localparam cs_word_t CFG0_DEFAULT = 32'h0007_f1fc;
    localparam cs_word_t CFG1_DEFAULT = 32'h0000_0001;
    localparam cs_word_t CFG2_DEFAULT = 32'h0000_0002;
    localparam cs_word_t CFG3_DEFAULT = 32'h0000_0003;
    localparam cs_bank_t CFG_DEFAULT  =
        {CFG3_DEFAULT, CFG2_DEFAULT, CFG1_DEFAULT, CFG0_DEFAULT};

    // host sequencer states
    typedef enum logic [2:0]
    {
        HS_IDLE,
        HS_LOW,
        HS_HIGH,
        HS_TAIL,
        HS_GAP
    } cs_host_state_e;

endpackage : cs_pkg

// ### cs_cfg_if.sv
// three-wire serial configuration link between host and device
`timescale 1ns/100ps
interface cs_cfg_if;

    logic ser_clk;            // serial shift clock, host driven
    logic ser_data;           // serial data, msb first
    logic word_latch_strobe;  // frame strobe, low during a word

    // host drives all three lines
    modport host
    (
        output ser_clk,
        output ser_data,
        output word_latch_strobe
    );

    // device only listens
    modport dev
    (
        input ser_clk,
        input ser_data,
        input word_latch_strobe
    );

endinterface : cs_cfg_if

// ### cs_cfg_dev.sv
// device end: serial shifter, four configuration words, core hand-over
// Functional notes
// (RULE1) three host-driven lines: clock, data, strobe
// (RULE2) four configuration registers, 32 bits each
// (RULE3) low two bits choose target register
// (RULE4) host sends 32 bits, msb first
// (RULE5) host zeroes test bits of fourth word; the host here sends every word unchanged
// (RULE6) falling strobe starts frame; shift while low
// (RULE7) strobe high: clock and data ignored
// (RULE8) data sampled on rising serial clock
// (RULE9) host raises strobe after last bit
// (RULE10) rising strobe commits word, no clock needed
// (RULE11) one strobe low period per word
// (RULE12) write only, nothing returned to host
// (RULE13) power-up or power-down restores defaults
// (RULE14) host should write all words after power-up
// (RULE15) odd-length frame commits last 32 bits
`timescale 1ns/100ps
module cs_cfg_dev
    import cs_pkg::*;
(
    input  wire logic      clk_i,           // core clock
    input  wire logic      nrst_i,          // core reset, active low
    input  wire logic      power_down_n_i,  // power-down, active low
    cs_cfg_if.dev          link,            // serial link, listen only
    output cs_bank_t       cfg_word_o,      // four words, core domain
    output logic           cfg_upd_o,       // one-cycle update pulse
    output cs_sel_t        cfg_idx_o        // index of updated word
);

    // ------------------------------------------------------------
    // link domain: serial shifter on the link clock
    // ------------------------------------------------------------

    cs_word_t  shift_r;       // incoming bits, newest at bit 0
    cs_word_t  shift_nxt;     // next shifter value

    // shift one bit per rising edge, only inside a frame
    always_comb
    begin
        // strobe high: hold, clock and data ignored
        shift_nxt = shift_r;                                   // (RULE7)
        // strobe low: msb arrives first, ends up on top
        if (!link.word_latch_strobe)                           // (RULE6)
        begin
            // a long frame just pushes old bits out the top
            shift_nxt = {shift_r[WORD_W-2:0], link.ser_data};  // (RULE15)
        end
    end

    // the strobe is steady around every serial edge in a frame,
    // and the clock may stop between frames, so it is read directly
    always_ff @(posedge link.ser_clk or negedge power_down_n_i)
    begin
        if (!power_down_n_i)
        begin
            // power-down clears the partial word
            shift_r <= '0;
        end
        else
        begin
            // data sampled on the rising clock edge
            shift_r <= shift_nxt;                              // (RULE8)
        end
    end

    // ------------------------------------------------------------
    // commit: clocked by the rising strobe itself
    // ------------------------------------------------------------

    cs_bank_t  cfg_r;         // the four configuration registers
    cs_bank_t  cfg_nxt;       // bank after this commit
    logic      tgl_r;         // flips once per commit
    logic      tgl_nxt;       // next toggle value
    cs_sel_t   idx_r;         // index of last committed word
    cs_sel_t   idx_nxt;       // next index value
    cs_sel_t   sel;           // select field of shifted word

    // pick the target from the two low bits and replace it
    always_comb
    begin
        sel                  = shift_r[SEL_LSB +: SEL_W];      // (RULE3)
        cfg_nxt              = cfg_r;
        // only the selected word changes; others keep value
        cfg_nxt[sel]         = shift_r;                        // (RULE2)
        tgl_nxt              = ~tgl_r;
        idx_nxt              = sel;
    end

    // no serial edge needed: the strobe edge itself latches
    always_ff @(posedge link.word_latch_strobe or negedge power_down_n_i)
    begin
        if (!power_down_n_i)
        begin
            // power-down returns every word to its default
            cfg_r <= CFG_DEFAULT;                              // (RULE13)
            tgl_r <= 1'b0;
            idx_r <= '0;
        end
        else
        begin
            // one commit per strobe low period
            cfg_r <= cfg_nxt;                                  // (RULE10)
            tgl_r <= tgl_nxt;                                  // (RULE11)
            idx_r <= idx_nxt;
        end
    end

    // ------------------------------------------------------------
    // core domain: synchronisers for commit toggle and power-down
    // ------------------------------------------------------------

    logic  tgl_meta_r;        // first stage, commit toggle
    logic  tgl_sync_r;        // second stage, commit toggle
    logic  tgl_seen_r;        // last toggle value acted on
    logic  pd_meta_r;         // first stage, power-down level
    logic  pd_sync_r;         // second stage, power-down level
    logic  tgl_meta_nxt;      // next first stage
    logic  tgl_sync_nxt;      // next second stage
    logic  tgl_seen_nxt;      // next acted-on value
    logic  pd_meta_nxt;       // next first stage
    logic  pd_sync_nxt;       // next second stage

    // two stages each; only the second stage feeds logic
    always_comb
    begin
        tgl_meta_nxt = tgl_r;
        tgl_sync_nxt = tgl_meta_r;
        tgl_seen_nxt = tgl_sync_r;
        pd_meta_nxt  = power_down_n_i;
        pd_sync_nxt  = pd_meta_r;
    end

    // synchroniser registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tgl_meta_r <= 1'b0;
            tgl_sync_r <= 1'b0;
            tgl_seen_r <= 1'b0;
            pd_meta_r  <= 1'b0;
            pd_sync_r  <= 1'b0;
        end
        else
        begin
            tgl_meta_r <= tgl_meta_nxt;
            tgl_sync_r <= tgl_sync_nxt;
            tgl_seen_r <= tgl_seen_nxt;
            pd_meta_r  <= pd_meta_nxt;
            pd_sync_r  <= pd_sync_nxt;
        end
    end

    // ------------------------------------------------------------
    // core domain: copy of the bank with update pulse
    // ------------------------------------------------------------

    cs_bank_t  words_r;       // core copy of the bank
    cs_bank_t  words_nxt;     // next core copy
    logic      upd_r;         // update pulse register
    logic      upd_nxt;       // next update pulse
    cs_sel_t   oidx_r;        // reported index
    cs_sel_t   oidx_nxt;      // next reported index

    // the bank is quiet for a whole frame after a commit,
    // so it is safe to sample once the toggle has crossed
    always_comb
    begin
        words_nxt = words_r;
        upd_nxt   = 1'b0;
        oidx_nxt  = oidx_r;
        if (!pd_sync_r)
        begin
            // power-down seen: core copy shows defaults too
            words_nxt = CFG_DEFAULT;                           // (RULE13)
        end
        else if (tgl_sync_r != tgl_seen_r)
        begin
            // a commit crossed over: take the bank, flag it
            words_nxt = cfg_r;
            upd_nxt   = 1'b1;
            oidx_nxt  = idx_r;
        end
    end

    // core output registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            words_r <= CFG_DEFAULT;
            upd_r   <= 1'b0;
            oidx_r  <= '0;
        end
        else
        begin
            words_r <= words_nxt;
            upd_r   <= upd_nxt;
            oidx_r  <= oidx_nxt;
        end
    end

    // outputs straight from flip-flops; the link modport has no
    // output, so nothing ever answers the host
    assign cfg_word_o = words_r;                               // (RULE12)
    assign cfg_upd_o  = upd_r;
    assign cfg_idx_o  = oidx_r;

endmodule : cs_cfg_dev

// ### cs_cfg_host.sv
// host end: serialises 32-bit words onto the three-wire link
`timescale 1ns/100ps
module cs_cfg_host
    import cs_pkg::*;
(
    input  wire logic      clk_i,        // host clock, 250 MHz
    input  wire logic      nrst_i,       // reset, active low
    input  wire logic      wr_req_i,     // request to send a word
    input  wire cs_word_t  wr_word_i,    // word to send
    output logic           wr_ready_o,   // idle, request taken
    output logic           wr_done_o,    // one-cycle frame done pulse
    cs_cfg_if.host         link          // serial link, drives all
);

    cs_host_state_e  st_r;       // sequencer state
    cs_host_state_e  st_nxt;     // next state
    cs_word_t        sh_r;       // word being sent, msb on top
    cs_word_t        sh_nxt;     // next shift value
    logic [4:0]      bit_r;      // bits still to send minus one
    logic [4:0]      bit_nxt;    // next bit count
    logic [7:0]      div_r;      // half-period divider
    logic [7:0]      div_nxt;    // next divider
    logic            sclk_r;     // serial clock out
    logic            sclk_nxt;   // next serial clock
    logic            sdat_r;     // serial data out
    logic            sdat_nxt;   // next serial data
    logic            le_r;       // strobe out, high when idle
    logic            le_nxt;     // next strobe
    logic            done_r;     // done pulse register
    logic            done_nxt;   // next done pulse
    logic            half_end;   // divider reached a half period

    // a request is taken only in idle; callers should write all
    // four words after power-up as part of their bring-up
    assign wr_ready_o = (st_r == HS_IDLE);                     // (RULE14)
    assign half_end   = (div_r == SCLK_HALF_CYC - 8'h01);

    // sequencer: strobe low, 32 clock pulses, strobe high, gap
    always_comb
    begin
        st_nxt   = st_r;
        sh_nxt   = sh_r;
        bit_nxt  = bit_r;
        div_nxt  = half_end ? 8'h00 : div_r + 8'h01;
        sclk_nxt = sclk_r;
        sdat_nxt = sdat_r;
        le_nxt   = le_r;
        done_nxt = 1'b0;
        case (st_r)
            HS_IDLE:
            begin
                // idle: strobe high, clock low
                div_nxt = 8'h00;
                if (wr_req_i)
                begin
                    // falling strobe opens the frame, msb first
                    le_nxt   = 1'b0;                           // (RULE6)
                    sh_nxt   = wr_word_i;
                    sdat_nxt = wr_word_i[WORD_W-1];            // (RULE4)
                    bit_nxt  = LAST_BIT;
                    st_nxt   = HS_LOW;
                end
            end
            HS_LOW:
            begin
                // data settles for a half period before rising edge
                if (half_end)
                begin
                    sclk_nxt = 1'b1;                           // (RULE8)
                    st_nxt   = HS_HIGH;
                end
            end
            HS_HIGH:
            begin
                // clock high; on fall move to next bit or finish
                if (half_end)
                begin
                    sclk_nxt = 1'b0;
                    if (bit_r == 5'h00)
                    begin
                        st_nxt = HS_TAIL;
                    end
                    else
                    begin
                        sh_nxt   = {sh_r[WORD_W-2:0], 1'b0};
                        sdat_nxt = sh_r[WORD_W-2];
                        bit_nxt  = bit_r - 5'h01;
                        st_nxt   = HS_LOW;
                    end
                end
            end
            HS_TAIL:
            begin
                // exactly 32 pulses sent; raise the strobe
                if (half_end)
                begin
                    le_nxt = 1'b1;                             // (RULE9)
                    st_nxt = HS_GAP;
                end
            end
            HS_GAP:
            begin
                // strobe high time before the next frame
                if (half_end)
                begin
                    done_nxt = 1'b1;                           // (RULE11)
                    st_nxt   = HS_IDLE;
                end
            end
            default:
            begin
                st_nxt = HS_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_r   <= HS_IDLE;
            sh_r   <= '0;
            bit_r  <= 5'h00;
            div_r  <= 8'h00;
            sclk_r <= 1'b0;
            sdat_r <= 1'b0;
            le_r   <= 1'b1;
            done_r <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            sh_r   <= sh_nxt;
            bit_r  <= bit_nxt;
            div_r  <= div_nxt;
            sclk_r <= sclk_nxt;
            sdat_r <= sdat_nxt;
            le_r   <= le_nxt;
            done_r <= done_nxt;
        end
    end

    // all three link lines from flip-flops
    assign link.ser_clk           = sclk_r;                    // (RULE1)
    assign link.ser_data          = sdat_r;
    assign link.word_latch_strobe = le_r;
    assign wr_done_o              = done_r;

endmodule : cs_cfg_host

// ### cs_cfg_assertions.sv
// link timing checker for the serial configuration port
`timescale 1ns/100ps
module cs_cfg_assertions
(
    input wire logic clk_i,             // host clock
    input wire logic nrst_i,            // reset, active low
    input wire logic ser_clk,           // serial shift clock
    input wire logic ser_data,          // serial data
    input wire logic word_latch_strobe  // frame strobe, low in a word
);
    logic [5:0] cnt_r;   // serial rises seen in this frame
    logic [5:0] cnt_nxt; // next rise count
    logic       sclk_r;  // serial clock one cycle ago

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // count rising serial edges while framed
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (word_latch_strobe)
            cnt_nxt = 6'h0;           // idle clears the count
        else if (ser_clk && !sclk_r)
            cnt_nxt = cnt_r + 6'h1;   // one more bit
    end

    // register helper state
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_r  <= 6'h0;
            sclk_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            sclk_r <= ser_clk;
        end
    end

    // one half period of the serial clock
    sequence sclk_low5;
        !ser_clk [*5];
    endsequence
    sequence sclk_high5;
        ser_clk [*5];
    endsequence

    chk_clk_idle_low: assert property (word_latch_strobe |-> !ser_clk)
        else $error("serial clock high outside a frame");
    chk_frame_start: assert property ($fell(word_latch_strobe) |->
        sclk_low5 ##1 ser_clk)
        else $error("first serial rise not a half period after strobe");
    chk_high_half: assert property ($rose(ser_clk) |->
        sclk_high5 ##1 !ser_clk)
        else $error("serial clock high phase wrong");
    chk_low_half: assert property ($fell(ser_clk) |->
        sclk_low5 ##1 (ser_clk || word_latch_strobe))
        else $error("serial clock low phase wrong");
    chk_data_stable: assert property (ser_clk |-> $stable(ser_data))
        else $error("data moved while serial clock high");
    chk_bit_count: assert property ($rose(word_latch_strobe) |->
        cnt_r == 6'h20)
        else $error("frame did not carry 32 rising edges");
    chk_strobe_end: assert property ($rose(word_latch_strobe) |->
        !$past(ser_clk, 5) && $past(ser_clk, 6))
        else $error("strobe not raised a half period after last bit");
    chk_frame_len: assert property ($fell(word_latch_strobe) |->
        ##[325:325] $rose(word_latch_strobe))
        else $error("frame length wrong");
    chk_gap_high: assert property ($rose(word_latch_strobe) |->
        word_latch_strobe [*6])
        else $error("strobe gap between words too short");
endmodule : cs_cfg_assertions

// ### clock_synth_config_serial_write_test.sv
// bench: host and device over the link, plus a bench-driven device
`timescale 1ns/100ps
module clock_synth_config_serial_write_test import cs_pkg::*;;
    logic        clk_i  = 1'b0;  // shared clock
    logic        nrst_i = 1'b0;  // reset, active low
    logic        pd_n   = 1'b1;  // power-down, active low
    logic        req    = 1'b0;  // host request
    cs_word_t    wd     = 32'h0; // host word
    wire         rdy;            // host idle
    wire         done;           // host frame done
    cs_bank_t    bank1;          // main device copy
    cs_bank_t    bank2;          // second device copy
    wire         upd1;           // main update pulse
    wire         upd2;           // second update pulse
    cs_sel_t     idx1;           // main update index
    cs_sel_t     idx2;           // second update index
    cs_word_t    exp1 [NUM_WORDS]; // expected main bank
    cs_word_t    sh   = 32'h0;   // word seen on the wire
    cs_word_t    last = 32'h0;   // word last sent
    logic [35:0] v36  = 36'h5_1234_5676; // overlong frame
    cs_word_t    wtab [NUM_WORDS] = '{32'h8000_0002, 32'h7fff_fffc,
                                      32'h0000_0a7f, 32'hc3a5_5a5d};
    int          nb = 0;         // bits seen on the wire
    int          nu1 = 0;        // main update pulses
    int          nu2 = 0;        // second update pulses
    int          n0;             // pulses before a step
    int          k;              // loop index
    int          bad_count = 0;  // mismatches
    int          n_checks = 0;   // comparisons

    cs_cfg_if lk();   // link between the two ends
    cs_cfg_if lk2();  // link driven by the bench

    cs_cfg_host u_cs_cfg_host (.clk_i(clk_i), .nrst_i(nrst_i),
        .wr_req_i(req), .wr_word_i(wd), .wr_ready_o(rdy),
        .wr_done_o(done), .link(lk.host));
    cs_cfg_dev u_cs_cfg_dev (.clk_i(clk_i), .nrst_i(nrst_i),
        .power_down_n_i(pd_n), .link(lk.dev), .cfg_word_o(bank1),
        .cfg_upd_o(upd1), .cfg_idx_o(idx1));
    cs_cfg_dev u_cs_cfg_dev_b (.clk_i(clk_i), .nrst_i(nrst_i),
        .power_down_n_i(pd_n), .link(lk2.dev), .cfg_word_o(bank2),
        .cfg_upd_o(upd2), .cfg_idx_o(idx2));
    cs_cfg_assertions u_cs_cfg_assertions (.clk_i(clk_i),
        .nrst_i(nrst_i), .ser_clk(lk.ser_clk), .ser_data(lk.ser_data),
        .word_latch_strobe(lk.word_latch_strobe));

    // 250 MHz clock
    initial
        forever #2 clk_i = ~clk_i;

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // verdict and stop
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    // one host write, then check the main bank
    task automatic send(input cs_word_t w);
        int i;
        int j;
        int c;
        c    = nu1;
        last = w;
        exp1[w[1:0]] = w;
        @(posedge clk_i);
        #1 req = 1'b1;
        wd = w;
        @(posedge clk_i);
        #1 req = 1'b0;
        chk(32'(rdy), 32'h0);
        for (i = 0; i < 400 && done !== 1'b1; i++)
            @(posedge clk_i) #1;
        chk(i, (2 * WORD_W + 2) * SCLK_HALF_RAW);
        chk(32'(rdy), 32'h1);
        for (j = 0; j < NUM_WORDS; j++)
            chk(bank1[j], exp1[j]);
        chk(32'(idx1), 32'(w[1:0]));
        chk(nu1, c + 1);
    endtask : send

    // one bit on the bench link, 30 ns serial period
    task automatic bit2(input logic v);
        lk2.ser_data = v;
        #15 lk2.ser_clk = 1'b1;
        #15 lk2.ser_clk = 1'b0;
    endtask : bit2

    // rebuild the word from the wire, msb first
    always @(posedge lk.ser_clk)
        if (lk.word_latch_strobe === 1'b0)
        begin
            sh = {sh[30:0], lk.ser_data};
            nb++;
        end

    // each frame end carries the word sent
    always @(posedge lk.word_latch_strobe)
        if (nrst_i)
        begin
            chk(sh, last);
            chk(nb, 32);
            nb = 0;
        end

    // count update pulses where settled
    always @(negedge clk_i)
    begin
        if (upd1 === 1'b1)
            nu1++;
        if (upd2 === 1'b1)
            nu2++;
    end

    // hang guard
    initial
    begin
        #60000;
        bad_count++;
        end_sim();
    end

    // main sequence
    initial
    begin
        lk2.ser_clk           = 1'b0;
        lk2.ser_data          = 1'b0;
        lk2.word_latch_strobe = 1'b1;
        @(posedge clk_i);
        // power-up: hold power-down low so both banks load defaults
        #1 pd_n = 1'b0;
        repeat (15) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        pd_n = 1'b1;
        for (k = 0; k < NUM_WORDS; k++)
        begin
            exp1[k] = CFG_DEFAULT[k];
            chk(bank1[k], exp1[k]);
        end
        chk(32'({lk.word_latch_strobe, lk.ser_clk}), 32'h2);
        $display("test reset done");
        for (k = 0; k < NUM_WORDS; k++)
            send(wtab[k]);
        $display("test writes done");
        pd_n = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        for (k = 0; k < NUM_WORDS; k++)
        begin
            exp1[k] = CFG_DEFAULT[k];
            chk(bank1[k], exp1[k]);
            chk(bank2[k], CFG_DEFAULT[k]);
        end
        pd_n = 1'b1;
        repeat (40) @(posedge clk_i);
        for (k = NUM_WORDS - 1; k >= 0; k--)
            send(wtab[k]);
        $display("test power down done");
        n0 = nu2;
        lk2.word_latch_strobe = 1'b0;
        for (k = 35; k >= 0; k--)
            bit2(v36[k]);
        #15 lk2.word_latch_strobe = 1'b1;
        lk2.ser_data = ~lk2.ser_data;
        for (k = 0; k < 8; k++)
            bit2(1'b1);
        lk2.word_latch_strobe = 1'b0;
        for (k = 3; k >= 0; k--)
            bit2(~k[0]);
        #15 lk2.word_latch_strobe = 1'b1;
        lk2.ser_data = ~lk2.ser_data;
        repeat (10) @(posedge clk_i);
        #1;
        chk(bank2[2], 32'h1234_5676);
        chk(bank2[1], 32'h2345_6765);
        chk(nu2, n0 + 2);
        chk(32'(idx2), 32'h1);
        $display("test odd frames done");
        end_sim();
    end
endmodule : clock_synth_config_serial_write_test
